/* design/spi_nvram_params.svh */
`ifndef SPI_NVRAM_PARAMS_SVH
`define SPI_NVRAM_PARAMS_SVH

`define OP_SET_WEL 8'h06
`define OP_CLR_WEL 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_MEM_WR 8'h02
`define OP_MEM_RD 8'h03
`define OP_MEM_FAST_RD 8'h0b

`define STAT_PPE_BIT 7
`define STAT_WEL_BIT 1
`define STAT_WR_MASK 8'h8c
`define STAT_RESET 8'h00

`define ADDR_BYTES 2'h3

`define MCLK_PERIOD_NS 20
`define SCK_HALF_NS 80
`define CS_GAP_NS 60
`define SCK_HALF_CYC ((`SCK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CS_GAP_CYC ((`CS_GAP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

/* design/spi_nvram_pkg.sv */
package spi_nvram_pkg;

  typedef enum logic [7:0] {
    dev_opcode = 8'h01,
    dev_addr = 8'h02,
    dev_dummy = 8'h04,
    dev_mem_wr = 8'h08,
    dev_mem_rd = 8'h10,
    dev_stat_wr = 8'h20,
    dev_stat_rd = 8'h40,
    dev_ignore = 8'h80
  } dev_state_type;

  typedef enum logic [6:0] {
    host_idle = 7'h01,
    host_lead = 7'h02,
    host_low = 7'h04,
    host_high = 7'h08,
    host_hold = 7'h10,
    host_trail = 7'h20,
    host_gap = 7'h40
  } host_state_type;

endpackage

/* design/spi_link_if.sv */
`timescale 1ns/10ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // An undriven output line is modelled as pulled high.
  assign miso = miso_oe ? miso_o : 1'b1;

  modport master (
    output cs_n,
    output sck,
    output mosi,
    input miso
  );

  modport slave (
    input cs_n,
    input sck,
    input mosi,
    output miso_o,
    output miso_oe
  );
endinterface

/* design/byte_fifo.sv */
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  function automatic logic [AW:0] next_ptr(input logic [AW:0] p);
    if (p[AW-1:0] == AW'(DEPTH - 1)) begin
      next_ptr = {~p[AW], {AW{1'b0}}};
    end else begin
      next_ptr = p + 1'b1;
    end
  endfunction

  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = store[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= next_ptr(wr_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= next_ptr(rd_q);
    end
  end
endmodule

/* design/spi_nvram_device.sv */
`timescale 1ns/10ps
`include "spi_nvram_params.svh"

// Summary of operation
// R1: Deselected: ignore inputs, output released.
// R2: Master reselects before every opcode.
// R3: Capture on rising, drive on falling.
// R4: Static logic; clock may stop anytime.
// R5: Master keeps data input at valid level.
// R6: Drive output only while shifting reads.
// R7: Protect pin blocks status writes when enabled.
// R8: Never drive while master is sending.
// R9: Eighteen-bit address selects one byte.
// R10: Address bits above seventeen are ignored.
// R11: Writes finish in transfer; no busy.
// R12: Works in mode zero and three.
// R13: First rising edge is command MSB.
// R14: Opcode first, then address, then data.
// R15: Master deselects after each operation.
// R16: Slave only; never starts transfers.
// R17: Deselect abandons command, counters go idle.
module spi_nvram_device #(
  parameter int ADDR_W = 18
) (
  spi_link_if.slave link,
  input wire logic srst,
  input wire logic wp_n,
  output logic [7:0] status
);
  localparam int MEM_SIZE = 1 << ADDR_W;

  logic [7:0] mem [MEM_SIZE];
  logic [2:0] bit_q;
  logic [6:0] shift_q;
  logic [1:0] byte_q;
  logic [7:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] rd_byte_q;
  logic [7:0] status_q;
  logic wp_s1_q;
  logic wp_s2_q;
  spi_nvram_pkg::dev_state_type state_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic [ADDR_W-1:0] addr_full;
  logic wel;
  logic stat_locked;
  logic addr_last;

  // Addresses roll over from the top location to zero within one burst.
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    next_addr = a + 1'b1;
  endfunction

  // Only the three array commands are followed by an address.
  function automatic logic takes_addr(input logic [7:0] op);
    takes_addr = (op == `OP_MEM_WR) || (op == `OP_MEM_RD) || (op == `OP_MEM_FAST_RD);
  endfunction

  assign byte_in = {shift_q, link.mosi};
  assign byte_done = (bit_q == 3'h7);
  assign addr_full = {addr_q[ADDR_W-9:0], byte_in};
  assign wel = status_q[`STAT_WEL_BIT];
  assign stat_locked = status_q[`STAT_PPE_BIT] && !wp_s2_q;
  assign status = status_q;
  assign addr_last = (state_q == spi_nvram_pkg::dev_addr) && (byte_q == `ADDR_BYTES - 2'h1);

  // The protect pin is quasi-static, so it is sampled on the serial clock.
  always_ff @(posedge link.sck) begin
    wp_s1_q <= wp_n;
    wp_s2_q <= wp_s1_q;
  end

  // Frame state is held clear whenever the part is deselected.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_q <= 3'h0; // R17
      shift_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1; // R13
      shift_q <= byte_in[6:0]; // R3 R4
    end
  end

  // Command sequencing; a partial frame is dropped as soon as the part is deselected.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      state_q <= spi_nvram_pkg::dev_opcode; // R1 R17
    end else if (byte_done) begin
      case (state_q)
        spi_nvram_pkg::dev_opcode: begin
          if (takes_addr(byte_in)) begin // R14
            state_q <= spi_nvram_pkg::dev_addr;
          end else if (byte_in == `OP_STAT_WR) begin
            state_q <= spi_nvram_pkg::dev_stat_wr;
          end else if (byte_in == `OP_STAT_RD) begin
            state_q <= spi_nvram_pkg::dev_stat_rd;
          end else begin
            // Unknown opcodes and finished one-byte commands ignore the rest.
            state_q <= spi_nvram_pkg::dev_ignore;
          end
        end
        spi_nvram_pkg::dev_addr: begin
          if (!addr_last) begin
            state_q <= spi_nvram_pkg::dev_addr;
          end else if (op_q == `OP_MEM_WR) begin
            state_q <= spi_nvram_pkg::dev_mem_wr;
          end else if (op_q == `OP_MEM_FAST_RD) begin
            state_q <= spi_nvram_pkg::dev_dummy;
          end else begin
            state_q <= spi_nvram_pkg::dev_mem_rd;
          end
        end
        spi_nvram_pkg::dev_dummy: begin
          state_q <= spi_nvram_pkg::dev_mem_rd;
        end
        spi_nvram_pkg::dev_mem_rd, spi_nvram_pkg::dev_mem_wr, spi_nvram_pkg::dev_stat_rd: begin
          // Bursts stay in their data phase until the master deselects.
          state_q <= state_q;
        end
        default: begin
          state_q <= spi_nvram_pkg::dev_ignore;
        end
      endcase
    end
  end

  // Opcode and address byte count are latched once per completed byte.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      op_q <= 8'h00;
      byte_q <= 2'h0;
    end else if (byte_done) begin
      if (state_q == spi_nvram_pkg::dev_opcode) begin
        op_q <= byte_in; // R14
      end
      if (state_q == spi_nvram_pkg::dev_addr) begin
        byte_q <= byte_q + 2'h1;
      end
    end
  end

  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      addr_q <= '0;
    end else if (byte_done) begin
      if (state_q == spi_nvram_pkg::dev_addr) begin
        addr_q <= addr_full; // R9 R10
      end else if (state_q == spi_nvram_pkg::dev_mem_rd || state_q == spi_nvram_pkg::dev_mem_wr) begin
        addr_q <= next_addr(addr_q); // R11
      end
    end
  end

  // The next outgoing byte is fetched on the edge that completes the previous one.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      rd_byte_q <= 8'h00;
    end else if (byte_done) begin
      if (state_q == spi_nvram_pkg::dev_opcode && byte_in == `OP_STAT_RD) begin
        rd_byte_q <= status_q;
      end else if (state_q == spi_nvram_pkg::dev_stat_rd) begin
        rd_byte_q <= status_q;
      end else if (addr_last && op_q == `OP_MEM_RD) begin
        rd_byte_q <= mem[addr_full];
      end else if (state_q == spi_nvram_pkg::dev_dummy) begin
        rd_byte_q <= mem[addr_q];
      end else if (state_q == spi_nvram_pkg::dev_mem_rd) begin
        rd_byte_q <= mem[next_addr(addr_q)];
      end
    end
  end

  // The array is written the instant a byte completes, so there is no busy phase.
  always_ff @(posedge link.sck) begin
    if (!link.cs_n && byte_done && wel && state_q == spi_nvram_pkg::dev_mem_wr) begin
      mem[addr_q] <= byte_in; // R11
    end
  end

  // Status bits survive deselection; besides the enable-clear and status-write commands, only the device reset clears them.
  always_ff @(posedge link.sck or posedge srst) begin
    if (srst) begin
      status_q <= `STAT_RESET;
    end else if (!link.cs_n && byte_done) begin
      if (state_q == spi_nvram_pkg::dev_opcode && byte_in == `OP_SET_WEL) begin
        status_q[`STAT_WEL_BIT] <= 1'b1;
      end else if (state_q == spi_nvram_pkg::dev_opcode && byte_in == `OP_CLR_WEL) begin
        status_q[`STAT_WEL_BIT] <= 1'b0;
      end else if (state_q == spi_nvram_pkg::dev_stat_wr && wel && !stat_locked) begin // R7
        status_q <= (byte_in & `STAT_WR_MASK) | (status_q & ~`STAT_WR_MASK);
      end
    end
  end

  // Output changes only on falling edges or at deselect, and only in the read phases, which
  // start after the master's last command bit; a shared data wire is safe.
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      link.miso_oe <= 1'b0; // R1 R6 R16
      link.miso_o <= 1'b0;
    end else begin
      link.miso_oe <= (state_q == spi_nvram_pkg::dev_mem_rd) ||
                      (state_q == spi_nvram_pkg::dev_stat_rd); // R6 R8
      link.miso_o <= rd_byte_q[~bit_q]; // R3 R12
    end
  end
endmodule

/* design/spi_nvram_host.sv */
`timescale 1ns/10ps
`include "spi_nvram_params.svh"

module spi_nvram_host #(
  parameter logic CPOL = 1'b0,
  parameter int HALF_CYC = `SCK_HALF_CYC,
  parameter int GAP_CYC = `CS_GAP_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy,
  spi_link_if.master link
);
  spi_nvram_pkg::host_state_type state_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic last_q;
  logic cs_n_q;
  logic sck_q;
  logic miso_s1_q;
  logic miso_s2_q;
  logic [8:0] f_data;
  logic f_valid;
  logic f_pop;
  logic tick;

  byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_data({tx_last, tx_data}),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  assign tick = (cnt_q == 8'h00);
  // A stalled frame simply holds the clock, which the slave tolerates.
  assign f_pop = f_valid && (state_q == spi_nvram_pkg::host_idle ||
                 (state_q == spi_nvram_pkg::host_hold && !last_q)); // R4
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.mosi = sh_q[7]; // R5
  assign busy = (state_q != spi_nvram_pkg::host_idle);

  always_ff @(posedge mclk) begin
    miso_s1_q <= link.miso;
    miso_s2_q <= miso_s1_q;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= spi_nvram_pkg::host_idle;
      cnt_q <= 8'h00;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      last_q <= 1'b0;
      cs_n_q <= 1'b1;
      sck_q <= CPOL;
    end else begin
      cnt_q <= tick ? 8'h00 : cnt_q - 8'h01;
      case (state_q)
        spi_nvram_pkg::host_idle: begin
          sck_q <= CPOL;
          if (f_valid) begin
            cs_n_q <= 1'b0; // R2
            sh_q <= f_data[7:0];
            last_q <= f_data[8];
            bit_q <= 3'h0;
            cnt_q <= 8'(HALF_CYC - 1);
            state_q <= spi_nvram_pkg::host_lead;
          end
        end
        spi_nvram_pkg::host_lead: begin
          if (tick) begin
            sck_q <= 1'b0;
            cnt_q <= 8'(HALF_CYC - 1);
            state_q <= spi_nvram_pkg::host_low;
          end
        end
        spi_nvram_pkg::host_low: begin
          if (tick) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[6:0], miso_s2_q};
            cnt_q <= 8'(HALF_CYC - 1);
            state_q <= spi_nvram_pkg::host_high;
          end
        end
        spi_nvram_pkg::host_high: begin
          if (tick) begin
            bit_q <= bit_q + 3'h1;
            sh_q <= {sh_q[6:0], 1'b0};
            cnt_q <= 8'(HALF_CYC - 1);
            if (bit_q == 3'h7) begin
              sck_q <= CPOL;
              state_q <= spi_nvram_pkg::host_hold;
            end else begin
              sck_q <= 1'b0;
              state_q <= spi_nvram_pkg::host_low;
            end
          end
        end
        spi_nvram_pkg::host_hold: begin
          if (last_q) begin
            state_q <= spi_nvram_pkg::host_trail;
          end else if (f_valid) begin
            sh_q <= f_data[7:0];
            last_q <= f_data[8];
            sck_q <= 1'b0;
            state_q <= spi_nvram_pkg::host_low;
          end
        end
        spi_nvram_pkg::host_trail: begin
          if (tick) begin
            cs_n_q <= 1'b1; // R15
            cnt_q <= 8'(GAP_CYC - 1);
            state_q <= spi_nvram_pkg::host_gap;
          end
        end
        default: begin
          if (tick) begin
            state_q <= spi_nvram_pkg::host_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= (state_q == spi_nvram_pkg::host_high) && tick && (bit_q == 3'h7);
      if ((state_q == spi_nvram_pkg::host_high) && tick && (bit_q == 3'h7)) begin
        rx_data <= rx_q;
      end
    end
  end
endmodule

/* verification/spi_link_monitor.sv */
`timescale 1ns/10ps
module spi_link_monitor #(
  parameter logic CPOL = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic [5:0] rise_q;
  logic sck_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  always_ff @(posedge mclk) begin
    sck_q <= sck;
  end
  // Rising link clock edges seen in the current frame; saturates so it never wraps.
  always_ff @(posedge mclk) begin
    if (cs_n) begin
      rise_q <= 6'h00;
    end else if (sck && !sck_q && rise_q != 6'h3f) begin
      rise_q <= rise_q + 6'h01;
    end
  end
  desel_release_a: assert property (cs_n |-> !miso_oe)
    else $error("output driven while deselected");
  drive_end_a: assert property ($fell(miso_oe) |-> $rose(cs_n))
    else $error("output released inside a read");
  out_on_fall_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> $fell(sck))
    else $error("output bit changed off a falling edge");
  drive_start_a: assert property ($rose(miso_oe) |-> $fell(sck) && !cs_n)
    else $error("drive began off a falling edge");
  no_cmd_drive_a: assert property (miso_oe |-> rise_q >= 6'h08)
    else $error("drive during opcode");
  in_stable_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("data moved at capture edge");
  idle_clock_a: assert property (cs_n |-> sck == CPOL)
    else $error("link clock moved while deselected");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("deselect gap too short");
  cover property ($rose(miso_oe));
  cover property ($rose(cs_n) && rise_q == 6'h28);
  cover property ($fell(cs_n));
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic srst;
  logic wp_n = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_ready, rx_valid, busy;
  logic [7:0] rx_data, status;
  logic [7:0] rxq[$];
  logic [7:0] fr[$];
  logic full_seen = 1'b0;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  spi_link_if link();
  spi_nvram_host spi_nvram_host_inst (.mclk(mclk), .srst(srst), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .busy(busy), .link(link.master));
  spi_nvram_device spi_nvram_device_inst (.link(link.slave), .srst(srst), .wp_n(wp_n),
    .status(status));
  spi_link_monitor #(.CPOL(1'b0)) spi_link_monitor_inst (.mclk(mclk), .srst(srst),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang cuts the run short; the whole sequence needs well under a fifth of this.
  // Outputs are collected mid-cycle, where they have settled.
  always @(negedge mclk) begin
    cyc++;
    if (rx_valid) begin
      rxq.push_back(rx_data);
    end
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Sends fr as one frame and waits until the host has closed it.
  task automatic run_frame(input string name);
    rxq.delete();
    foreach (fr[i]) begin
      @(negedge mclk);
      tx_data = fr[i];
      tx_last = (i == fr.size() - 1);
      tx_valid = 1'b1;
      while (!tx_ready) begin
        full_seen = 1'b1;
        @(negedge mclk);
      end
      @(posedge mclk);
    end
    @(negedge mclk);
    tx_valid = 1'b0;
    repeat (3) @(negedge mclk);
    while (busy) @(negedge mclk);
    check({name, "_count"}, 8'(rxq.size()), 8'(fr.size()));
    $display("test %s done", name);
  endtask
  task automatic all_high(input int first);
    for (int i = first; i < fr.size(); i++) check("released", rxq[i], 8'hff);
  endtask
  initial begin
    // Reset must arrive as an edge, since the device clears its status asynchronously.
    srst = 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    fr = {8'h06};
    run_frame("wel_set");
    check("status", status, 8'h02);
    fr = {8'h01, 8'hff};
    run_frame("stat_wr");
    check("status", status, 8'h8e);
    all_high(0);
    wp_n = 1'b0;
    fr = {8'h01, 8'h00};
    run_frame("stat_locked");
    check("status", status, 8'h8e);
    wp_n = 1'b1;
    run_frame("stat_unlocked");
    check("status", status, 8'h02);
    // Upper address bits set on purpose; twenty bytes overrun the host buffer.
    fr = {8'h02, 8'hfc, 8'h00, 8'h05};
    for (int i = 0; i < 20; i++) fr.push_back(8'h40 + 8'(i));
    run_frame("mem_wr");
    check("fifo_full", {7'h00, full_seen}, 8'h01);
    all_high(0);
    fr = {8'h03, 8'h00, 8'h00, 8'h05};
    for (int i = 0; i < 20; i++) fr.push_back(8'h00);
    run_frame("mem_rd");
    for (int i = 0; i < 20; i++) check("rd", rxq[4 + i], 8'h40 + 8'(i));
    for (int i = 0; i < 4; i++) check("hdr", rxq[i], 8'hff);
    fr = {8'h0b, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
    run_frame("fast_rd");
    check("fast", rxq[5], 8'h42);
    fr = {8'h02, 8'h03, 8'hff, 8'hff, 8'ha5, 8'h5a};
    run_frame("wrap_wr");
    fr = {8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    run_frame("wrap_rd");
    check("wrap", rxq[4], 8'h5a);
    fr = {8'h03, 8'hff, 8'hff, 8'hff, 8'h00};
    run_frame("top_rd");
    check("top", rxq[4], 8'ha5);
    fr = {8'h05, 8'h00, 8'h00};
    run_frame("stat_rd");
    check("stat0", rxq[1], 8'h02);
    check("stat1", rxq[2], 8'h02);
    fr = {8'h04};
    run_frame("wel_clr");
    check("status", status, 8'h00);
    fr = {8'h02, 8'h00, 8'h00, 8'h05, 8'hee};
    run_frame("wr_locked");
    fr = {8'h03, 8'h00, 8'h00, 8'h05, 8'h00};
    run_frame("rd_kept");
    check("kept", rxq[4], 8'h40);
    fr = {8'h9f, 8'h00, 8'h00};
    run_frame("bad_op");
    all_high(0);
    fr = {8'h05, 8'h00};
    run_frame("after_bad");
    check("recover", rxq[1], 8'h00);
    end_sim();
  end
endmodule
